/* core/csr_pkg.sv */
// register window constants, field masks and carrier types
// assumes a byte-offset register block placed by a user-chosen upper address byte
// Contract
// - 256-byte register block decoded at user base
// - register selected by fixed offset from base
// - input register returns live pin levels
// - output register latched and driven on pins
// - direction bit picks pin input or output
// - ports E, F, G select latched address out
// - drive bit: open-drain or fast slew per port
// - main flash protection read-only, writes ignored
// - boot protection and security read-only
// - mapping register places areas program/data space
// - identification reports main flash and SRAM sizes
// - identification reports boot type and size
// - port E pins 1-3 carry JTAG TCK/TDI/TDO
// - port E pin 4 programming status or busy
// - port E pin 5 active-low programming error
// - port E pin 7 battery-in-use indicator
// - port F pins 1-3 low address inputs
// - non-multiplexed bus: F data low, G high
package csr_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_PORTS = 7;
  localparam int PORT_E    = 4;
  localparam int PORT_F    = 5;
  localparam int PORT_G    = 6;
  localparam int SYNC_W    = 91;

  // ==========================================================
  // per-port offsets, order A B C D E F G
  localparam logic [7:0] PORT_IN_OFS  [NUM_PORTS] =
    '{8'h00, 8'h01, 8'h10, 8'h11, 8'h30, 8'h40, 8'h41};
  localparam logic [7:0] PORT_OUT_OFS [NUM_PORTS] =
    '{8'h04, 8'h05, 8'h14, 8'h15, 8'h34, 8'h44, 8'h45};
  localparam logic [7:0] PORT_DIR_OFS [NUM_PORTS] =
    '{8'h06, 8'h07, 8'h16, 8'h17, 8'h36, 8'h46, 8'h47};
  localparam logic [7:0] PORT_DRV_OFS [NUM_PORTS] =
    '{8'h08, 8'h09, 8'h18, 8'h19, 8'h38, 8'h48, 8'h49};
  localparam logic [7:0] PORT_CTL_OFS [NUM_PORTS] =
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h42, 8'h43};
  localparam logic [6:0] HAS_CTL      = 7'h70;
  localparam logic [6:0] DRV_IS_SLEW  = 7'h24;
  localparam logic [6:0] ADDR_HI_OUT  = 7'h40;

  // ==========================================================
  // other registers
  localparam logic [7:0] OFS_PWR_CTL0  = 8'hB0;
  localparam logic [7:0] OFS_PWR_CTL2  = 8'hB4;
  localparam logic [7:0] OFS_MAIN_PROT = 8'hC0;
  localparam logic [7:0] OFS_BOOT_PROT = 8'hC2;
  localparam logic [7:0] OFS_PAGE      = 8'hE0;
  localparam logic [7:0] OFS_SPACE_MAP = 8'hE2;
  localparam logic [7:0] OFS_MEM_ID0   = 8'hF0;
  localparam logic [7:0] OFS_MEM_ID1   = 8'hF1;

  localparam logic [7:0] PWR_CTL0_MASK   = 8'h3A;
  localparam logic [7:0] PWR_CTL2_MASK   = 8'h7D;
  localparam logic [7:0] SPACE_MAP_MASK  = 8'h1F;
  localparam logic [7:0] SPACE_MAP_STRAP = 8'h1E;
  localparam logic [7:0] RST_BYTE        = 8'h00;

  // arbitrary neutral size codes
  localparam logic [7:0] MEM_SIZE_INFO_0 = 8'h11;
  localparam logic [7:0] MEM_SIZE_INFO_1 = 8'h22;

  // ==========================================================
  // carriers
  typedef logic [7:0] csr_byte_t;

  typedef struct packed {
    csr_byte_t ctl;
    csr_byte_t out;
    csr_byte_t dir;
    csr_byte_t drv;
  } csr_port_cfg_t;

  typedef struct packed {
    csr_byte_t out;
    csr_byte_t oe;
  } csr_pin_drv_t;

  typedef enum logic [2:0] {
    CSR_IDLE  = 3'b001,
    CSR_READ  = 3'b010,
    CSR_WRITE = 3'b100
  } csr_state_t;

endpackage

/* core/csr_regs.sv */
// register window and port pin logic of the flash peripheral
// assumes host strobes, address and pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module csr_regs
  import csr_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  input  wire logic [15:0]                 host_addr,
  input  wire logic [15:0]                 host_data_in,
  input  wire logic                        host_rd_n,
  input  wire logic                        host_wr_n,
  input  wire logic [7:0]                  block_base,
  output logic      [15:0]                 host_data_out,
  output logic                             host_data_oe,
  output logic                             register_block_select,
  input  wire csr_byte_t [NUM_PORTS-1:0]   pin_in,
  output csr_pin_drv_t   [NUM_PORTS-1:0]   pin_drv,
  output csr_byte_t      [NUM_PORTS-1:0]   pin_fast_slew,
  input  wire logic                        jtag_enable,
  input  wire logic                        jtag_tdo_in,
  output logic                             jtag_tck,
  output logic                             jtag_tdi,
  input  wire logic                        isp_mode,
  input  wire logic                        isp_status_in,
  input  wire logic                        isp_error_n_in,
  input  wire logic                        battery_ind_enable,
  input  wire logic                        battery_on_in,
  input  wire logic                        xa_mode,
  output logic      [2:0]                  xa_addr_low,
  input  wire logic                        nonmux_mode,
  input  wire logic [7:0]                  main_flash_prot,
  input  wire logic [3:0]                  boot_flash_prot,
  input  wire logic                        security_set,
  input  wire logic [4:0]                  space_map_strap,
  output logic      [7:0]                  page_select,
  output logic      [7:0]                  power_mgmt_ctrl_0,
  output logic      [7:0]                  power_mgmt_ctrl_2,
  output logic      [7:0]                  memory_space_map
);

  // ==========================================================
  // synchronisers
  logic [SYNC_W-1:0]         sync_q;
  logic                      rd_n_s;
  logic                      wr_n_s;
  logic [15:0]               addr_s;
  logic [15:0]               data_s;
  csr_byte_t [NUM_PORTS-1:0] pin_s;
  logic                      batt_s;

  // strobes reset high so no phantom access follows reset
  csr_sync #(
    .W   (SYNC_W),
    .RST ({2'b11, 89'h0})
  ) csr_sync_i (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .d       ({host_rd_n, host_wr_n, host_addr, host_data_in, pin_in, battery_on_in}),
    .q       (sync_q)
  );

  assign {rd_n_s, wr_n_s, addr_s, data_s, pin_s, batt_s} = sync_q;

  // ==========================================================
  // bus cycle tracking
  csr_state_t state;
  csr_state_t next_state;
  logic [15:0] lat_addr;
  logic [7:0]  lat_data;
  logic        lat_hit;
  logic        wr_commit;
  logic [7:0]  next_wr_byte;
  logic        hit;

  assign hit = (addr_s[15:8] == block_base);

  // in non-multiplexed mode the data byte rides on port F or G
  always_comb
  begin
    if (nonmux_mode)
      next_wr_byte = addr_s[0] ? pin_s[PORT_G] : pin_s[PORT_F];
    else
      next_wr_byte = addr_s[0] ? data_s[15:8] : data_s[7:0];
  end

  always_comb
  begin
    next_state = state;
    case (state)
      CSR_IDLE:
      begin
        if (!rd_n_s)
          next_state = CSR_READ;
        else if (!wr_n_s)
          next_state = CSR_WRITE;
      end
      CSR_READ:
      begin
        if (rd_n_s)
          next_state = CSR_IDLE;
      end
      CSR_WRITE:
      begin
        if (wr_n_s)
          next_state = CSR_IDLE;
      end
      default:
        next_state = CSR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= CSR_IDLE;
    else
      state <= next_state;
  end

  // address and data are sampled every cycle the strobe stays low, starting a cycle after it is seen,
  // giving the synchronised bus at least one extra cycle to settle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lat_addr <= 16'h0000;
      lat_data <= 8'h00;
      lat_hit  <= 1'b0;
    end
    else if (state != CSR_IDLE && ((state == CSR_READ && !rd_n_s) ||
                                   (state == CSR_WRITE && !wr_n_s)))
    begin
      lat_addr <= addr_s;
      lat_data <= next_wr_byte;
      lat_hit  <= hit;
    end
  end

  assign wr_commit = (state == CSR_WRITE) && wr_n_s && lat_hit;

  // ==========================================================
  // port configuration registers
  csr_port_cfg_t [NUM_PORTS-1:0] cfg;

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port_cfg
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
      if (!rst_b)
        cfg[p] <= '0;
      else if (wr_commit)
      begin
        if (lat_addr[7:0] == PORT_OUT_OFS[p])
          cfg[p].out <= lat_data;
        else if (lat_addr[7:0] == PORT_DIR_OFS[p])
          cfg[p].dir <= lat_data;
        else if (lat_addr[7:0] == PORT_DRV_OFS[p])
          cfg[p].drv <= lat_data;
        else if (HAS_CTL[p] && lat_addr[7:0] == PORT_CTL_OFS[p])
          cfg[p].ctl <= lat_data;
      end
    end
  end

  // ==========================================================
  // power, page and mapping registers
  logic map_loaded;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      page_select       <= RST_BYTE;
      power_mgmt_ctrl_0 <= RST_BYTE;
      power_mgmt_ctrl_2 <= RST_BYTE;
    end
    else if (wr_commit)
    begin
      if (lat_addr[7:0] == OFS_PAGE)
        page_select <= lat_data;
      else if (lat_addr[7:0] == OFS_PWR_CTL0)
        power_mgmt_ctrl_0 <= lat_data & PWR_CTL0_MASK;
      else if (lat_addr[7:0] == OFS_PWR_CTL2)
        power_mgmt_ctrl_2 <= lat_data & PWR_CTL2_MASK;
    end
  end

  // configured space bits are caught just after reset release;
  // the bus needs several cycles to reach a commit, so no race
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memory_space_map <= RST_BYTE;
      map_loaded       <= 1'b0;
    end
    else if (!map_loaded)
    begin
      memory_space_map <= {3'b000, space_map_strap} & SPACE_MAP_STRAP;
      map_loaded       <= 1'b1;
    end
    else if (wr_commit && lat_addr[7:0] == OFS_SPACE_MAP)
      memory_space_map <= lat_data & SPACE_MAP_MASK;
  end

  // ==========================================================
  // read path
  logic [7:0] next_rd;
  logic [7:0] rd_data;

  // protection, security and size bytes have no write path at all
  always_comb
  begin
    next_rd = 8'h00;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (addr_s[7:0] == PORT_IN_OFS[p])
        next_rd = pin_s[p];
      else if (addr_s[7:0] == PORT_OUT_OFS[p])
        next_rd = cfg[p].out;
      else if (addr_s[7:0] == PORT_DIR_OFS[p])
        next_rd = cfg[p].dir;
      else if (addr_s[7:0] == PORT_DRV_OFS[p])
        next_rd = cfg[p].drv;
      else if (HAS_CTL[p] && addr_s[7:0] == PORT_CTL_OFS[p])
        next_rd = cfg[p].ctl;
    end
    if (addr_s[7:0] == OFS_PWR_CTL0)
      next_rd = power_mgmt_ctrl_0;
    else if (addr_s[7:0] == OFS_PWR_CTL2)
      next_rd = power_mgmt_ctrl_2;
    else if (addr_s[7:0] == OFS_MAIN_PROT)
      next_rd = main_flash_prot;
    else if (addr_s[7:0] == OFS_BOOT_PROT)
      next_rd = {security_set, 3'b000, boot_flash_prot};
    else if (addr_s[7:0] == OFS_PAGE)
      next_rd = page_select;
    else if (addr_s[7:0] == OFS_SPACE_MAP)
      next_rd = memory_space_map;
    else if (addr_s[7:0] == OFS_MEM_ID0)
      next_rd = MEM_SIZE_INFO_0;
    else if (addr_s[7:0] == OFS_MEM_ID1)
      next_rd = MEM_SIZE_INFO_1;
  end

  // the read byte is refreshed while the strobe is low so input
  // ports stay live; same byte on both lanes
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data               <= 8'h00;
      host_data_out         <= 16'h0000;
      host_data_oe          <= 1'b0;
      register_block_select <= 1'b0;
    end
    else
    begin
      register_block_select <= (state != CSR_IDLE) && hit;
      if (state == CSR_READ && !rd_n_s && hit)
      begin
        rd_data       <= next_rd;
        host_data_out <= {next_rd, next_rd};
        host_data_oe  <= !nonmux_mode;
      end
      else
        host_data_oe <= 1'b0;
    end
  end

  // ==========================================================
  // pin drivers
  csr_pin_drv_t [NUM_PORTS-1:0] next_drv;
  logic                         reading;

  assign reading = nonmux_mode && host_data_oe == 1'b0 && state == CSR_READ &&
                   lat_hit && !rd_n_s;

  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        logic val;
        logic en;
        val = ADDR_HI_OUT[p] ? lat_addr[8 + b] : lat_addr[b];
        en  = 1'b0;
        if (HAS_CTL[p] && cfg[p].ctl[b])
          en = 1'b1;
        else
        begin
          val = cfg[p].out[b];
          en  = cfg[p].dir[b];
        end
        next_drv[p].out[b] = val;
        // open-drain drives only a low level
        if (!DRV_IS_SLEW[p] && cfg[p].drv[b])
          next_drv[p].oe[b] = en && !val;
        else
          next_drv[p].oe[b] = en;
      end
    end
    if (jtag_enable)
    begin
      next_drv[PORT_E].oe[1]  = 1'b0;
      next_drv[PORT_E].oe[2]  = 1'b0;
      next_drv[PORT_E].out[3] = jtag_tdo_in;
      next_drv[PORT_E].oe[3]  = 1'b1;
    end
    if (isp_mode)
    begin
      next_drv[PORT_E].out[4] = isp_status_in;
      next_drv[PORT_E].oe[4]  = 1'b1;
      next_drv[PORT_E].out[5] = isp_error_n_in;
      next_drv[PORT_E].oe[5]  = 1'b1;
    end
    if (battery_ind_enable)
    begin
      next_drv[PORT_E].out[7] = batt_s;
      next_drv[PORT_E].oe[7]  = 1'b1;
    end
    if (xa_mode)
      next_drv[PORT_F].oe[3:0] = 4'h0;
    if (nonmux_mode)
    begin
      next_drv[PORT_F].out = rd_data;
      next_drv[PORT_F].oe  = {8{reading}};
      next_drv[PORT_G].out = rd_data;
      next_drv[PORT_G].oe  = {8{reading}};
    end
  end

  // a nonmux read turns the lanes round one cycle after rd_data loads
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_drv       <= '0;
      pin_fast_slew <= '0;
    end
    else
    begin
      pin_drv <= next_drv;
      for (int p = 0; p < NUM_PORTS; p++)
        pin_fast_slew[p] <= DRV_IS_SLEW[p] ? cfg[p].drv : 8'h00;
    end
  end

  // ==========================================================
  // special function inputs
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      jtag_tck    <= 1'b0;
      jtag_tdi    <= 1'b0;
      xa_addr_low <= 3'b000;
    end
    else
    begin
      jtag_tck    <= jtag_enable && pin_s[PORT_E][1];
      jtag_tdi    <= jtag_enable && pin_s[PORT_E][2];
      xa_addr_low <= xa_mode ? pin_s[PORT_F][3:1] : 3'b000;
    end
  end

endmodule // csr_regs
`default_nettype wire

/* core/csr_sync.sv */
// two-flop synchroniser for a vector of asynchronous levels
// assumes each bit is independent or stable while it is consumed
`timescale 1ns/1ps
`default_nettype none
module csr_sync
  import csr_pkg::*;
#(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
)
(
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= RST;
      q    <= RST;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // csr_sync
`default_nettype wire

/* test/csr_host_model.sv */
// host partner: 16-bit controller issuing byte cycles
// assumes strobe hold and recovery of the bus contract
`timescale 1ns/1ps
`default_nettype none
module csr_host_model
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] host_data_out,
  output logic      [15:0] host_addr,
  output logic      [15:0] host_data_in,
  output logic             host_rd_n,
  output logic             host_wr_n
);
  initial
  begin
    host_addr    = 16'h0000;
    host_data_in = 16'h0000;
    host_rd_n    = 1'b1;
    host_wr_n    = 1'b1;
  end

  // ==========================================================
  // byte cycle: strobe low 8 cycles, high 6
  task automatic cycle(
    input  logic        rd,
    input  logic [15:0] a,
    input  logic [7:0]  d,
    output logic [15:0] q
  );
    @(posedge ref_clk);
    #1;
    host_addr    = a;
    host_data_in = a[0] ? {d, ~d} : {~d, d};
    host_rd_n    = !rd;
    host_wr_n    = rd;
    repeat (8) @(posedge ref_clk);
    #1;
    q = host_data_out;
    host_rd_n    = 1'b1;
    host_wr_n    = 1'b1;
    // released lines never keep the last value
    host_data_in = ~host_data_in;
    host_addr    = ~host_addr;
    repeat (6) @(posedge ref_clk);
    // return off the edge so callers never race the design's flops
    #1;
  endtask
endmodule // csr_host_model
`default_nettype wire

/* test/csr_regs_checker.sv */
// port checker for the register window and pin logic
// assumes one clock, ref_clk, and async active-low rst_b
`timescale 1ns/1ps
`default_nettype none
module csr_regs_checker
  import csr_pkg::*;
(
  input wire logic                      ref_clk,
  input wire logic                      rst_b,
  input wire logic [15:0]               host_addr,
  input wire logic                      host_rd_n,
  input wire logic [7:0]                block_base,
  input wire logic                      host_data_oe,
  input wire logic                      register_block_select,
  input wire csr_byte_t [NUM_PORTS-1:0] pin_in,
  input wire csr_pin_drv_t [NUM_PORTS-1:0] pin_drv,
  input wire csr_byte_t [NUM_PORTS-1:0] pin_fast_slew,
  input wire logic                      jtag_enable,
  input wire logic                      jtag_tdo_in,
  input wire logic                      jtag_tck,
  input wire logic                      jtag_tdi,
  input wire logic                      isp_mode,
  input wire logic                      isp_error_n_in,
  input wire logic                      battery_ind_enable,
  input wire logic                      battery_on_in,
  input wire logic                      xa_mode,
  input wire logic [2:0]                xa_addr_low,
  input wire logic                      nonmux_mode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // host bus
  sequence s_rd_idle;
    host_rd_n[*6];
  endsequence

  chk_sel_on_hit: assert property (
    $rose(register_block_select) |-> host_addr[15:8] == block_base)
    else $error("select raised without a base hit");
  chk_oe_on_read: assert property (
    $rose(host_data_oe) |-> !host_rd_n && !nonmux_mode)
    else $error("data driven outside a muxed read");
  chk_oe_released: assert property (
    s_rd_idle |-> !host_data_oe)
    else $error("data lanes still driven after read");

  // ==========================================================
  // pins
  chk_slew_ports: assert property (
    {pin_fast_slew[6], pin_fast_slew[4:3], pin_fast_slew[1:0]} == 40'h0)
    else $error("slew enable on a port without slew control");
  chk_jtag_in: assert property (
    (jtag_enable && pin_in[PORT_E][2:1] == 2'b11)[*4] |-> jtag_tck && jtag_tdi)
    else $error("clock or data input not passed through");
  chk_jtag_off: assert property (
    (!jtag_enable)[*2] |-> !jtag_tck && !jtag_tdi)
    else $error("test inputs active while disabled");
  chk_tdo_drive: assert property (
    (jtag_enable && jtag_tdo_in)[*2] |-> pin_drv[PORT_E].out[3])
    else $error("test output not on pin 3");
  chk_isp_error: assert property (
    (isp_mode && !isp_error_n_in)[*2]
      |-> pin_drv[PORT_E].oe[5] && !pin_drv[PORT_E].out[5])
    else $error("error pin not pulled low");
  chk_battery_pin: assert property (
    (battery_ind_enable && battery_on_in)[*4] |-> pin_drv[PORT_E].out[7])
    else $error("battery indicator not high");
  chk_xa_addr: assert property (
    (xa_mode && $stable(pin_in[PORT_F]))[*4] |-> xa_addr_low == pin_in[PORT_F][3:1])
    else $error("low address bits not taken from port pins");
  chk_xa_input: assert property (
    (xa_mode && !nonmux_mode)[*2] |-> pin_drv[PORT_F].oe[3:0] == 4'h0)
    else $error("address pins driven in address mode");
endmodule // csr_regs_checker

bind csr_regs csr_regs_checker csr_regs_checker_i (
  .ref_clk, .rst_b, .host_addr, .host_rd_n, .block_base, .host_data_oe,
  .register_block_select, .pin_in, .pin_drv, .pin_fast_slew, .jtag_enable,
  .jtag_tdo_in, .jtag_tck, .jtag_tdi, .isp_mode, .isp_error_n_in,
  .battery_ind_enable, .battery_on_in, .xa_mode, .xa_addr_low, .nonmux_mode
);
`default_nettype wire

/* test/test_csr_regs.sv */
// self-checking bench for the register window
// assumes the host partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_csr_regs;
  import csr_pkg::*;
  logic                     ref_clk = 1'b0;
  logic                     rst_b;
  logic [15:0]              host_addr, host_data_in, host_data_out, rq;
  logic                     host_rd_n, host_wr_n, host_data_oe;
  logic                     register_block_select;
  logic [7:0]               block_base, main_flash_prot, page_select;
  logic [7:0]               power_mgmt_ctrl_0, power_mgmt_ctrl_2, memory_space_map;
  csr_byte_t [NUM_PORTS-1:0] pin_in, pin_fast_slew;
  csr_pin_drv_t [NUM_PORTS-1:0] pin_drv;
  logic                     jtag_enable, jtag_tdo_in, jtag_tck, jtag_tdi;
  logic                     isp_mode, isp_status_in, isp_error_n_in;
  logic                     battery_ind_enable, battery_on_in, xa_mode, nonmux_mode;
  logic [2:0]               xa_addr_low;
  logic [3:0]               boot_flash_prot;
  logic                     security_set;
  logic [4:0]               space_map_strap;
  int                       n_fail = 0;
  int                       total_checks = 0;
  int                       cyc = 0;

  always #25 ref_clk = ~ref_clk;

  csr_regs csr_regs_i (
    .ref_clk, .rst_b, .host_addr, .host_data_in, .host_rd_n, .host_wr_n,
    .block_base, .host_data_out, .host_data_oe, .register_block_select, .pin_in,
    .pin_drv, .pin_fast_slew, .jtag_enable, .jtag_tdo_in, .jtag_tck, .jtag_tdi,
    .isp_mode, .isp_status_in, .isp_error_n_in, .battery_ind_enable,
    .battery_on_in, .xa_mode, .xa_addr_low, .nonmux_mode, .main_flash_prot,
    .boot_flash_prot, .security_set, .space_map_strap, .page_select,
    .power_mgmt_ctrl_0, .power_mgmt_ctrl_2, .memory_space_map
  );
  csr_host_model csr_host_model_i (
    .ref_clk, .host_data_out, .host_addr, .host_data_in, .host_rd_n, .host_wr_n
  );

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] o, d);
    csr_host_model_i.cycle(1'b0, {block_base, o}, d, rq);
  endtask

  // reads copy the byte onto both lanes
  task automatic rd_chk(input string what, input logic [7:0] o, exp);
    csr_host_model_i.cycle(1'b1, {block_base, o}, 8'h00, rq);
    check(what, rq, {exp, exp});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rst_b = 1'b0;
    step(4);
    rst_b = 1'b1;
    step(2);
    check("map_port", memory_space_map, 8'h14);
    check("oe_rst", pin_drv[0].oe, 8'h00);
    rd_chk("map", OFS_SPACE_MAP, 8'h14);
    rd_chk("gap", 8'h33, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_rw();
    logic [7:0] v;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      v = 8'h3C ^ 8'(i);
      wr(PORT_OUT_OFS[i], v);
      rd_chk("out", PORT_OUT_OFS[i], v);
      wr(PORT_DIR_OFS[i], ~v);
      rd_chk("dir", PORT_DIR_OFS[i], ~v);
      wr(PORT_DRV_OFS[i], v ^ 8'h81);
      rd_chk("drv", PORT_DRV_OFS[i], v ^ 8'h81);
      if (HAS_CTL[i])
      begin
        wr(PORT_CTL_OFS[i], v ^ 8'h42);
        rd_chk("ctl", PORT_CTL_OFS[i], v ^ 8'h42);
      end
    end
    wr(OFS_PWR_CTL0, 8'hFF);
    rd_chk("pm0", OFS_PWR_CTL0, PWR_CTL0_MASK);
    wr(OFS_PWR_CTL2, 8'hFF);
    check("pm2", power_mgmt_ctrl_2, PWR_CTL2_MASK);
    wr(OFS_SPACE_MAP, 8'hFF);
    check("map_w", memory_space_map, SPACE_MAP_MASK);
    // the page must not move while the strobe is still low
    fork
      wr(OFS_PAGE, 8'hA7);
      begin
        repeat (8) @(posedge ref_clk);
        check("page_early", page_select, 8'h00);
      end
    join
    check("page", page_select, 8'hA7);
    $display("test read write done");
  endtask

  task automatic t_ro();
    wr(OFS_MAIN_PROT, 8'hFF);
    rd_chk("prot", OFS_MAIN_PROT, 8'h9C);
    wr(OFS_BOOT_PROT, 8'hFF);
    rd_chk("boot", OFS_BOOT_PROT, 8'h86);
    rd_chk("id0", OFS_MEM_ID0, MEM_SIZE_INFO_0);
    rd_chk("id1", OFS_MEM_ID1, MEM_SIZE_INFO_1);
    wr(8'hFF, 8'hFF);
    rd_chk("gap_hi", 8'hFF, 8'h00);
    csr_host_model_i.cycle(1'b0, {~block_base, OFS_PAGE}, 8'h01, rq);
    check("miss", page_select, 8'hA7);
    $display("test read only done");
  endtask

  task automatic t_pins();
    pin_in[2] = 8'h5A;
    rd_chk("in_c", PORT_IN_OFS[2], 8'h5A);
    wr(PORT_OUT_OFS[0], 8'hC3);
    wr(PORT_DIR_OFS[0], 8'h0F);
    wr(PORT_DRV_OFS[0], 8'h01);
    check("a_oe", pin_drv[0].oe, 8'h0E);
    check("a_out", pin_drv[0].out[3:1], 3'h1);
    wr(PORT_DRV_OFS[2], 8'h81);
    check("slew", pin_fast_slew[2], 8'h81);
    for (int i = PORT_E; i < NUM_PORTS; i += 2)
    begin
      wr(PORT_DRV_OFS[i], 8'h00);
      wr(PORT_DIR_OFS[i], 8'hFF);
      wr(PORT_CTL_OFS[i], 8'hFF);
    end
    check("g_addr", pin_drv[PORT_G].out, block_base);
    check("e_addr", pin_drv[PORT_E].out, PORT_CTL_OFS[PORT_G]);
    $display("test pins done");
  endtask

  task automatic t_modes();
    jtag_enable = 1'b1;
    jtag_tdo_in = 1'b1;
    pin_in[PORT_E] = 8'h06;
    isp_mode = 1'b1;
    isp_error_n_in = 1'b0;
    isp_status_in = 1'b1;
    battery_ind_enable = 1'b1;
    battery_on_in = 1'b1;
    xa_mode = 1'b1;
    pin_in[PORT_F] = 8'h0A;
    step(6);
    check("tck", {jtag_tck, jtag_tdi}, 2'b11);
    check("stat", pin_drv[PORT_E].out[4], 1'b1);
    check("err", pin_drv[PORT_E].out[5], 1'b0);
    check("bat", pin_drv[PORT_E].out[7], 1'b1);
    check("xa", xa_addr_low, 3'h5);
    jtag_enable = 1'b0;
    isp_mode = 1'b0;
    battery_ind_enable = 1'b0;
    xa_mode = 1'b0;
    nonmux_mode = 1'b1;
    pin_in[PORT_F] = 8'h6B;
    wr(OFS_PAGE, 8'h00);
    check("nonmux", page_select, 8'h6B);
    // a nonmux read turns port F and G round while the strobe is low
    fork
      csr_host_model_i.cycle(1'b1, {block_base, OFS_PAGE}, 8'h00, rq);
      begin
        repeat (7) @(posedge ref_clk);
        check("nm_oe", pin_drv[PORT_F].oe, 8'hFF);
        check("nm_g", pin_drv[PORT_G].out, 8'h6B);
      end
    join
    nonmux_mode = 1'b0;
    $display("test modes done");
  endtask

  // ==========================================================
  // run and hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    block_base = 8'hC7;
    pin_in = '0;
    jtag_enable = 1'b0;
    jtag_tdo_in = 1'b0;
    isp_mode = 1'b0;
    isp_status_in = 1'b0;
    isp_error_n_in = 1'b1;
    battery_ind_enable = 1'b0;
    battery_on_in = 1'b0;
    xa_mode = 1'b0;
    nonmux_mode = 1'b0;
    main_flash_prot = 8'h9C;
    boot_flash_prot = 4'h6;
    security_set = 1'b1;
    space_map_strap = 5'h15;
    t_reset();
    t_rw();
    t_ro();
    t_pins();
    t_modes();
    t_reset();
    finish_test();
  end
endmodule // test_csr_regs
`default_nettype wire
